//--- design/change_compare_and_config.sv
// Purpose: Per-pin change compare, device configuration and interrupt pin
// Assumes: Pins and link clock are asynchronous; registers over AHB-Lite
// Notes:   Link clock is sampled; its rising edge at each byte end steps the address pointer
`timescale 1ns/100ps
`include "change_compare_defs.svh"

module change_compare_and_config #(
  parameter int  PIN_COUNT   = 8,
  parameter bit  SPI_VARIANT = 1'b1
) (
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  input  wire logic [PIN_COUNT-1:0] port_pins,
  input  wire logic                 link_clk,
  input  wire logic                 link_byte_done,
  output logic      [7:0]           addr_pointer,
  output logic                      sda_slew_limit,
  output logic                      addr_pins_used,
  output change_compare_pkg::irq_pin_t irq_pin,
  output logic                      irq
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [PIN_COUNT-1:0] change_irq_enable_q;
  logic [PIN_COUNT-1:0] default_compare_value_q;
  logic [PIN_COUNT-1:0] compare_mode_select_q;
  logic [PIN_COUNT-1:0] pin_direction_q;
  logic [PIN_COUNT-1:0] prev_value_q;
  logic [PIN_COUNT-1:0] int_flags_q;
  logic [PIN_COUNT-1:0] captured_port_value_q;
  logic [1:0]           event_status_q;
  logic [1:0]           event_mask_q;
  change_compare_pkg::device_configuration_t device_configuration_q;
  logic [PIN_COUNT-1:0] pin_meta_q;
  logic [PIN_COUNT-1:0] pin_sync_q;
  logic [2:0]           lclk_q;
  logic [1:0]           lbyte_q;
  logic                 irq_active_q;
  change_compare_pkg::ahb_phase_t phase_q;
  logic [7:0]           idx_q;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
      lclk_q     <= 3'h0;
      lbyte_q    <= 2'h0;
    end else begin
      pin_meta_q <= port_pins;
      pin_sync_q <= pin_meta_q;
      lclk_q     <= {lclk_q[1:0], link_clk};
      lbyte_q    <= {lbyte_q[0], link_byte_done};
    end
  end

  // Byte boundary: link clock rising edge while byte-done is high
  logic byte_edge;
  assign byte_edge = lclk_q[1] & ~lclk_q[2] & lbyte_q[1];

  // ----------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // ----------------------------------------------------------------
  logic       take;
  logic [7:0] a_idx;
  assign take  = hsel & htrans[1] & hready;
  assign a_idx = haddr[`ADDR_LSB +: 8];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_q <= change_compare_pkg::AHB_IDLE;
      idx_q   <= `RST_BYTE;
    end else if (hready) begin
      phase_q <= !take ? change_compare_pkg::AHB_IDLE :
                 hwrite ? change_compare_pkg::AHB_WRITE : change_compare_pkg::AHB_READ;
      idx_q   <= a_idx;
    end
  end

  logic wr;
  logic rd_cap;
  logic [7:0] wdat;
  assign wr     = phase_q == change_compare_pkg::AHB_WRITE;
  assign wdat   = hwdata[7:0];
  // Reads of capture or port clear the pending interrupt
  assign rd_cap = take & ~hwrite & (a_idx == `IDX_CAPTURED_PORT || a_idx == `IDX_PORT_VALUE);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      change_irq_enable_q     <= '0;
      default_compare_value_q <= '0;
      compare_mode_select_q   <= '0;
      pin_direction_q         <= {PIN_COUNT{1'b1}};
      device_configuration_q  <= `RST_BYTE;
      event_mask_q            <= 2'h0;
    end else if (wr) begin
      case (idx_q)
        `IDX_CHANGE_IRQ_ENABLE: change_irq_enable_q <= wdat[PIN_COUNT-1:0];
        `IDX_DEFAULT_COMPARE:   default_compare_value_q <= wdat[PIN_COUNT-1:0];
        `IDX_COMPARE_MODE:      compare_mode_select_q <= wdat[PIN_COUNT-1:0];
        `IDX_PIN_DIRECTION:     pin_direction_q <= wdat[PIN_COUNT-1:0];
        `IDX_DEVICE_CONFIG:     device_configuration_q <= wdat & `CFG_WRITE_MASK;
        `IDX_EVENT_MASK:        event_mask_q <= wdat[1:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    hrdata = 32'h0;
    if (phase_q == change_compare_pkg::AHB_READ) begin
      case (idx_q)
        `IDX_CHANGE_IRQ_ENABLE: hrdata[PIN_COUNT-1:0] = change_irq_enable_q;
        `IDX_DEFAULT_COMPARE:   hrdata[PIN_COUNT-1:0] = default_compare_value_q;
        `IDX_COMPARE_MODE:      hrdata[PIN_COUNT-1:0] = compare_mode_select_q;
        `IDX_PIN_DIRECTION:     hrdata[PIN_COUNT-1:0] = pin_direction_q;
        // zeros in bits 7, 6, 0
        `IDX_DEVICE_CONFIG:     hrdata[7:0] = device_configuration_q & `CFG_WRITE_MASK;
        `IDX_INT_FLAGS:         hrdata[PIN_COUNT-1:0] = int_flags_q;
        `IDX_CAPTURED_PORT:     hrdata[PIN_COUNT-1:0] = captured_port_value_q;
        `IDX_PORT_VALUE:        hrdata[PIN_COUNT-1:0] = pin_sync_q;
        `IDX_EVENT_STATUS:      hrdata[1:0] = event_status_q;
        `IDX_EVENT_MASK:        hrdata[1:0] = event_mask_q;
        `IDX_ADDR_POINTER:      hrdata[7:0] = addr_pointer;
        default:                hrdata = 32'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Per-pin change detection
  // ----------------------------------------------------------------
  logic [PIN_COUNT-1:0] cond;
  genvar g;
  generate
    for (g = 0; g < PIN_COUNT; g++) begin : g_pin
      logic ref_bit;
      assign ref_bit = compare_mode_select_q[g] ? default_compare_value_q[g] : prev_value_q[g];
      assign cond[g] = change_irq_enable_q[g] & pin_direction_q[g] &
                       (pin_sync_q[g] ^ ref_bit);
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_value_q <= '0;
    end else begin
      prev_value_q <= pin_sync_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_flags_q           <= '0;
      captured_port_value_q <= '0;
      irq_active_q          <= 1'b0;
    end else begin
      int_flags_q <= int_flags_q | cond;
      if (cond != '0 && !irq_active_q) begin
        captured_port_value_q <= pin_sync_q;
        irq_active_q          <= 1'b1;
      end else if (rd_cap) begin
        // Set wins: a condition in the read cycle stays pending
        irq_active_q <= |cond;
        int_flags_q  <= cond;
      end
    end
  end

  // ----------------------------------------------------------------
  // Event status, mask, interrupt line
  // ----------------------------------------------------------------
  logic [1:0] evt;
  assign evt = {byte_edge, cond != '0 && !irq_active_q};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      event_status_q <= 2'h0;
    end else begin
      // Set wins over write-one clear
      event_status_q <= (event_status_q & ~((wr && idx_q == `IDX_EVENT_STATUS) ?
                        wdat[1:0] : 2'h0)) | evt;
    end
  end
  assign irq = |(event_status_q & event_mask_q);

  always_comb begin
    if (device_configuration_q.irq_open_drain) begin
      irq_pin.out  = 1'b0;
      irq_pin.oe_n = ~irq_active_q;
    end else begin
      irq_pin.out  = device_configuration_q.irq_active_level ? irq_active_q : ~irq_active_q;
      irq_pin.oe_n = 1'b0;
    end
  end

  assign sda_slew_limit = ~device_configuration_q.sda_edge_limit_off;
  assign addr_pins_used = SPI_VARIANT ? device_configuration_q.addr_pin_enable : 1'b1;

  // ----------------------------------------------------------------
  // Address pointer on link byte boundaries
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_pointer <= `RST_BYTE;
    end else if (wr && idx_q == `IDX_ADDR_POINTER) begin
      addr_pointer <= wdat;
    end else if (byte_edge && !device_configuration_q.pointer_hold) begin
      addr_pointer <= (addr_pointer == `POINTER_LAST) ? `RST_BYTE : addr_pointer + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_CFG_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
    phase_q == change_compare_pkg::AHB_READ && idx_q == `IDX_DEVICE_CONFIG
      |-> hrdata[7:6] == 2'h0 && hrdata[0] == 1'b0)
    else $error("config unimplemented bits not zero");
  AST_DEF_MISMATCH: assert property (@(posedge hclk) disable iff (!hresetn)
    (change_irq_enable_q & pin_direction_q & compare_mode_select_q &
     (pin_sync_q ^ default_compare_value_q)) != '0 |=> irq_active_q)
    else $error("default mismatch did not raise interrupt");
  AST_OUTPUT_PIN_QUIET: assert property (@(posedge hclk) disable iff (!hresetn)
    (cond & ~pin_direction_q) == '0)
    else $error("output pin caused condition");
  AST_ENABLE_GATE: assert property (@(posedge hclk) disable iff (!hresetn)
    (cond & ~change_irq_enable_q) == '0)
    else $error("disabled pin caused condition");
  AST_PREV_TRACK: assert property (@(posedge hclk) disable iff (!hresetn)
    1'b1 |=> prev_value_q == $past(pin_sync_q))
    else $error("previous value not tracked");
  AST_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
    byte_edge && device_configuration_q.pointer_hold && !wr |=> $stable(addr_pointer))
    else $error("pointer moved while held");
  AST_OD: assert property (@(posedge hclk) disable iff (!hresetn)
    device_configuration_q.irq_open_drain |-> irq_pin.out == 1'b0)
    else $error("open drain drives high");
  AST_POL: assert property (@(posedge hclk) disable iff (!hresetn)
    !device_configuration_q.irq_open_drain |->
      irq_pin.out == (irq_active_q ~^ device_configuration_q.irq_active_level))
    else $error("interrupt polarity wrong");
  AST_PERSIST: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_cap && (cond & compare_mode_select_q) != '0 |=> irq_active_q)
    else $error("default condition lost on read");

  // ----------------------------------------------------------------
  // Checks built from steps
  // ----------------------------------------------------------------
  // previous-value change, then capture
  sequence seq_prev_change;
    (change_irq_enable_q & pin_direction_q & ~compare_mode_select_q &
     (pin_sync_q ^ prev_value_q)) != '0 && !irq_active_q;
  endsequence
  sequence seq_prev_captured;
    irq_active_q && captured_port_value_q == $past(pin_sync_q);
  endsequence
  AST_PREV_CAPTURE: assert property (@(posedge hclk) disable iff (!hresetn)
    seq_prev_change |=> seq_prev_captured)
    else $error("previous-value change not captured");
  AST_PREV_QUIET: assert property (@(posedge hclk) disable iff (!hresetn)
    $stable(pin_sync_q) |-> (cond & ~compare_mode_select_q) == '0)
    else $error("stable pin raised previous-value condition");

  AST_CFG_STORE: assert property (@(posedge hclk) disable iff (!hresetn)
    device_configuration_q.unused_hi == 2'h0 && device_configuration_q.unused_lo == 1'b0)
    else $error("unimplemented config bits stored");
  AST_PTR_STEP: assert property (@(posedge hclk) disable iff (!hresetn)
    byte_edge && !device_configuration_q.pointer_hold &&
      !(wr && idx_q == `IDX_ADDR_POINTER)
      |=> addr_pointer == (($past(addr_pointer) == `POINTER_LAST) ? `RST_BYTE :
                           $past(addr_pointer) + 8'h01))
    else $error("pointer did not step");

  AST_OD_RELEASE: assert property (@(posedge hclk) disable iff (!hresetn)
    device_configuration_q.irq_open_drain |-> irq_pin.oe_n == ~irq_active_q)
    else $error("open drain enable wrong");
  AST_PP_DRIVE: assert property (@(posedge hclk) disable iff (!hresetn)
    !device_configuration_q.irq_open_drain |-> irq_pin.oe_n == 1'b0)
    else $error("push-pull pin not driven");
  AST_SLEW: assert property (@(posedge hclk) disable iff (!hresetn)
    sda_slew_limit == ~device_configuration_q.sda_edge_limit_off)
    else $error("slew control output wrong");
  AST_ADDR_PINS: assert property (@(posedge hclk) disable iff (!hresetn)
    addr_pins_used == (SPI_VARIANT ? device_configuration_q.addr_pin_enable : 1'b1))
    else $error("address pin enable wrong");

  AST_DEF_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
    wr && idx_q == `IDX_DEFAULT_COMPARE |=> default_compare_value_q == $past(wdat[PIN_COUNT-1:0]))
    else $error("reference bits not written");
  AST_MODE_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
    wr && idx_q == `IDX_COMPARE_MODE |=> compare_mode_select_q == $past(wdat[PIN_COUNT-1:0]))
    else $error("compare select bits not written");
  AST_ENABLE_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
    wr && idx_q == `IDX_CHANGE_IRQ_ENABLE |=> change_irq_enable_q == $past(wdat[PIN_COUNT-1:0]))
    else $error("change enable bits not written");
  AST_DIR_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
    wr && idx_q == `IDX_PIN_DIRECTION |=> pin_direction_q == $past(wdat[PIN_COUNT-1:0]))
    else $error("direction bits not written");

endmodule // change_compare_and_config

//--- design/change_compare_defs.svh
// Purpose: Constants for the change-compare and configuration block
// Assumes: Included by the design module only
// Notes:   Register byte addresses are word index times four
`ifndef CHANGE_COMPARE_DEFS_SVH
`define CHANGE_COMPARE_DEFS_SVH

// ----------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------
`define IDX_CHANGE_IRQ_ENABLE   8'h02
`define IDX_DEFAULT_COMPARE     8'h03
`define IDX_COMPARE_MODE        8'h04
`define IDX_DEVICE_CONFIG       8'h05
`define IDX_PIN_DIRECTION       8'h00
`define IDX_INT_FLAGS           8'h07
`define IDX_CAPTURED_PORT       8'h08
`define IDX_PORT_VALUE          8'h09
`define IDX_EVENT_STATUS        8'h10
`define IDX_EVENT_MASK          8'h11
`define IDX_ADDR_POINTER        8'h12
`define ADDR_LSB                2

// ----------------------------------------------------------------
// Configuration field positions and reset values
// ----------------------------------------------------------------
`define CFG_POINTER_HOLD        5
`define CFG_SDA_LIMIT_OFF       4
`define CFG_ADDR_PIN_EN         3
`define CFG_IRQ_OPEN_DRAIN      2
`define CFG_IRQ_ACTIVE_LEVEL    1
`define CFG_WRITE_MASK          8'h3e
`define RST_BYTE                8'h00
`define RST_DIRECTION           8'hff
`define POINTER_LAST            8'h0a
`define EVT_CHANGE              0
`define EVT_LINK_BYTE           1

`endif

//--- design/change_compare_pkg.sv
// Purpose: Types for the change-compare and configuration block
// Assumes: Constants come from the defs header
// Notes:   Nothing here is imported; users write the scoped name
package change_compare_pkg;

  // ----------------------------------------------------------------
  // Configuration register layout
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] unused_hi;
    logic       pointer_hold;
    logic       sda_edge_limit_off;
    logic       addr_pin_enable;
    logic       irq_open_drain;
    logic       irq_active_level;
    logic       unused_lo;
  } device_configuration_t;

  // Interrupt pin drive, two signals of an open-drain capable pin
  typedef struct packed {
    logic out;
    logic oe_n;
  } irq_pin_t;

  typedef enum logic [1:0] {
    AHB_IDLE  = 2'b00,
    AHB_WRITE = 2'b01,
    AHB_READ  = 2'b10
  } ahb_phase_t;

endpackage

//--- testbench/link_host_model.sv
// Purpose: Host side of the serial link, clock and byte-end marks
// Assumes: Link clock stands low between frames
// Notes:   A byte ends on every eighth rising edge of the frame
`timescale 1ns/100ps
module link_host_model #(
  parameter real HALF_NS = 80.0
) (
  output logic link_clk,
  output logic link_byte_done
);
  initial begin
    link_clk = 1'b0;
    link_byte_done = 1'b0;
  end

  // ----------------------------------------------------------------
  // Frame of whole bytes
  // ----------------------------------------------------------------
  task automatic send_bytes(input int n);
    // Step off the sampling edge of the block clock
    #1;
    for (int b = 0; b < n; b++) begin
      for (int k = 0; k < 8; k++) begin
        link_byte_done = (k == 7);
        #(HALF_NS) link_clk = 1'b1;
        #(HALF_NS) link_clk = 1'b0;
      end
    end
    link_byte_done = 1'b0;
  endtask
endmodule // link_host_model

//--- testbench/testbench.sv
// Purpose: Self-checking bench for change compare and configuration
// Assumes: Single AHB-Lite master, zero-wait slave, link model on the far side
// Notes:   Pin changes get a settle time for the two-stage synchroniser
`timescale 1ns/100ps
module testbench;
  logic        hclk, hresetn, hsel, hwrite, hready;
  logic [31:0] haddr, hwdata, hrdata, rd, v;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hreadyout, hresp, sda_slew_limit, addr_pins_used, irq;
  logic [7:0]  port_pins, addr_pointer, dv;
  logic        link_clk, link_byte_done;
  change_compare_pkg::irq_pin_t irq_pin;
  int          num_errors, n_checks, cycles;

  assign hready = hreadyout;

  change_compare_and_config i_change_compare_and_config (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .port_pins(port_pins), .link_clk(link_clk),
    .link_byte_done(link_byte_done), .addr_pointer(addr_pointer),
    .sda_slew_limit(sda_slew_limit), .addr_pins_used(addr_pins_used),
    .irq_pin(irq_pin), .irq(irq));

  link_host_model i_link_host_model (.link_clk(link_clk), .link_byte_done(link_byte_done));

  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {22'h0, idx, 2'b00};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rchk(input string what, input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    chk(what, rd, exp);
  endtask

  // Expected pin drive: open drain pulls low when active, else floats
  task automatic pchk(input logic [7:0] cfg, input logic act);
    chk("irq pin", {30'h0, irq_pin}, {30'h0, cfg[2] ? {1'b0, ~act} : {act ~^ cfg[1], 1'b0}});
  endtask

  task automatic pins(input logic [7:0] p);
    port_pins <= p;
    repeat (8) @(posedge hclk);
  endtask

  task automatic conclude();
    if (num_errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  always @(posedge hclk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(81));
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'b010;
    port_pins = 8'h00;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk("default", 8'h03, 32'h0);
    rchk("mode", 8'h04, 32'h0);
    rchk("config", 8'h05, 32'h0);
    pchk(8'h00, 1'b0);
    for (int i = 0; i < 8; i++) begin
      v = $urandom;
      dv = v[7:0];
      bus(1'b1, 8'h03, v);
      bus(1'b1, 8'h04, ~v);
      rchk("default", 8'h03, {24'h0, v[7:0]});
      rchk("mode", 8'h04, {24'h0, ~v[7:0]});
    end
    for (int k = 0; k < 16; k++) begin
      v = (k == 0) ? 32'hffffffc1 : $urandom;
      bus(1'b1, 8'h05, v);
      rchk("config", 8'h05, v & 32'h3e);
      chk("slew", {31'h0, sda_slew_limit}, {31'h0, ~v[4]});
      chk("addr pins", {31'h0, addr_pins_used}, {31'h0, v[3]});
      pchk(v[7:0], 1'b0);
    end
    rchk("default", 8'h03, {24'h0, dv});
    bus(1'b1, 8'h02, 32'h03);
    bus(1'b1, 8'h03, 32'h00);
    bus(1'b1, 8'h04, 32'h01);
    bus(1'b1, 8'h05, 32'h02);
    pins(8'h04);
    pchk(8'h02, 1'b0);
    pins(8'h01);
    pchk(8'h02, 1'b1);
    rchk("flags", 8'h07, 32'h01);
    bus(1'b0, 8'h09, 32'h0);
    repeat (8) @(posedge hclk);
    pchk(8'h02, 1'b1);
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, 8'h05, {29'h0, c[1:0], 1'b0});
      @(posedge hclk);
      pchk({5'h0, c[1:0], 1'b0}, 1'b1);
    end
    bus(1'b1, 8'h05, 32'h02);
    bus(1'b1, 8'h00, 32'hfe);
    bus(1'b0, 8'h09, 32'h0);
    repeat (8) @(posedge hclk);
    pchk(8'h02, 1'b0);
    bus(1'b1, 8'h00, 32'hff);
    pins(8'h00);
    bus(1'b0, 8'h09, 32'h0);
    repeat (8) @(posedge hclk);
    pchk(8'h02, 1'b0);
    pins(8'h02);
    pchk(8'h02, 1'b1);
    rchk("capture", 8'h08, 32'h02);
    repeat (8) @(posedge hclk);
    pchk(8'h02, 1'b0);
    pins(8'h00);
    bus(1'b0, 8'h09, 32'h0);
    bus(1'b1, 8'h11, 32'h00);
    bus(1'b1, 8'h10, 32'h03);
    bus(1'b1, 8'h12, 32'h09);
    i_link_host_model.send_bytes(3);
    @(posedge hclk);
    chk("pointer", {24'h0, addr_pointer}, 32'h01);
    chk("irq masked", {31'h0, irq}, 32'h0);
    rchk("status", 8'h10, 32'h02);
    bus(1'b1, 8'h11, 32'h02);
    @(posedge hclk);
    chk("irq", {31'h0, irq}, 32'h1);
    bus(1'b1, 8'h10, 32'h02);
    @(posedge hclk);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    bus(1'b1, 8'h05, 32'h20);
    i_link_host_model.send_bytes(2);
    @(posedge hclk);
    rchk("pointer held", 8'h12, 32'h01);
    rchk("unmapped", 8'h06, 32'h0);
    conclude();
  end
endmodule // testbench
